// [rtl/ttr_defines.svh]
`ifndef TTR_DEFINES_SVH
`define TTR_DEFINES_SVH

// Register byte addresses
`define TTR_ADDR_W 12
`define TTR_ADDR_SEL 12'h000
`define TTR_ADDR_MASTER 12'h004
`define TTR_ADDR_CMD 12'h008
`define TTR_ADDR_STATUS 12'h00C

// Field widths and positions
`define TTR_SEL_W 14
`define TTR_SEL_RST 14'h0000
`define TTR_SB_W 6
`define TTR_MASTER_RST 6'h00
`define TTR_CMD_SW_ACQ 0
`define TTR_CMD_SW_OUT 1
`define TTR_ST_SEL_LSB 0
`define TTR_ST_ACQ_BUSY 16
`define TTR_ST_OUT_BUSY 17
`define TTR_ST_PENDING 18
`define TTR_ST_MASTER_LSB 24

// Master tick source codes
`define TTR_TICK_INT 2'h0
`define TTR_TICK_EXT 2'h1
`define TTR_TICK_SYNC 2'h2

// Trigger source codes
`define TTR_TRIG_SW 2'h0
`define TTR_TRIG_EXT 2'h1
`define TTR_TRIG_ANA 2'h2
`define TTR_TRIG_SYNC 2'h3

// Strobe source codes
`define TTR_SRC_INT 2'h0
`define TTR_SRC_AUX 2'h1
`define TTR_SRC_SYNC 2'h2

// Sync bus line index
`define TTR_SB_TICK 0
`define TTR_SB_ACQ 1
`define TTR_SB_SCAN 2
`define TTR_SB_CONV 3
`define TTR_SB_OTRIG 4
`define TTR_SB_UPD 5

// Synchroniser input index
`define TTR_PIN_W 11
`define TTR_PIN_TICK 0
`define TTR_PIN_ACQ 1
`define TTR_PIN_WAVE 2
`define TTR_PIN_AUX0 3
`define TTR_PIN_AUX1 4
`define TTR_PIN_SB 5

`endif

// [rtl/ttr_pkg.sv]
package ttr_pkg;

    // Source selection, packed in register bit order
    typedef struct packed {
        logic wave_fall;
        logic acq_fall;
        logic [1:0] upd;
        logic [1:0] otrig;
        logic [1:0] conv;
        logic [1:0] scan;
        logic [1:0] atrig;
        logic [1:0] tick;
    } ttr_sel_t;

endpackage

// [rtl/ttr_edge_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface ttr_edge_if #(parameter int W = 1) (
    input wire logic clk,
    input wire logic rst_n
);
    logic [W-1:0] raw;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport det (input clk, input rst_n, input raw, output rise, output fall);
    modport user (output raw, input rise, input fall);
endinterface

`default_nettype wire

// [rtl/ttr_edge_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module ttr_edge_sync #(
    parameter int W = 1
) (
    ttr_edge_if.det e
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Two-stage synchroniser; only s2 reads s1
    always_ff @(posedge e.clk or negedge e.rst_n) begin
        if (!e.rst_n) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= e.raw;
            s2 <= s1;
        end
    end

    // One-cycle pulse per edge
    always_ff @(posedge e.clk or negedge e.rst_n) begin
        if (!e.rst_n) begin
            s3 <= '0;
            e.rise <= '0;
            e.fall <= '0;
        end else begin
            s3 <= s2;
            e.rise <= s2 & ~s3;
            e.fall <= ~s2 & s3;
        end
    end
endmodule

`default_nettype wire

// [rtl/ttr_router.sv]
`include "ttr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ttr_router (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`TTR_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Internal generators and engine state, same clock
    input wire logic int_scan_pulse,
    input wire logic int_conv_pulse,
    input wire logic int_upd_pulse,
    input wire logic analog_trigger,
    input wire logic acq_busy,
    input wire logic out_busy,
    // Connector pins, asynchronous
    input wire logic external_tick_input,
    input wire logic acq_ext_trigger_pin,
    input wire logic wave_ext_trigger_pin,
    input wire logic aux_input_0,
    input wire logic aux_input_1,
    // Card sync bus, one line per timing signal
    input wire logic [`TTR_SB_W-1:0] sync_bus_in,
    output logic [`TTR_SB_W-1:0] sync_bus_out,
    output logic [`TTR_SB_W-1:0] sync_bus_oe_n,
    // Routed timing signals
    output logic master_tick,
    output logic acq_trigger,
    output logic scan_begin,
    output logic convert_strobe,
    output logic output_trigger,
    output logic output_update_strobe
);
    ttr_pkg::ttr_sel_t pend_sel;
    ttr_pkg::ttr_sel_t act_sel;
    logic [`TTR_SB_W-1:0] master_n;
    logic sw_acq;
    logic sw_out;
    logic [4:0] pend;
    logic [4:0] ev;
    logic tick_now;
    logic aux_conv;
    logic acq_ev;
    logic scan_ev;
    logic conv_ev;
    logic otrig_ev;
    logic upd_ev;
    logic [4:0] next_fire;
    logic [4:0] ev_keep;
    logic [`TTR_PIN_W-1:0] rise;
    logic [`TTR_PIN_W-1:0] fall;
    logic wr_en;
    logic rd_setup;
    logic [31:0] next_prdata;

    ttr_edge_if #(.W(`TTR_PIN_W)) pins_if (.clk(pclk), .rst_n(presetn));

    // All pins cross into pclk before use
    assign pins_if.raw = {sync_bus_in, aux_input_1, aux_input_0, wave_ext_trigger_pin,
                          acq_ext_trigger_pin, external_tick_input};
    assign rise = pins_if.rise;
    assign fall = pins_if.fall;

    ttr_edge_sync #(.W(`TTR_PIN_W)) u_sync (.e(pins_if.det));

    function automatic logic addr_hit(input logic [`TTR_ADDR_W-1:0] a);
        addr_hit = (a == `TTR_ADDR_SEL) || (a == `TTR_ADDR_MASTER) ||
                   (a == `TTR_ADDR_CMD) || (a == `TTR_ADDR_STATUS);
    endfunction

    // APB handshake, zero wait states
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit(paddr);
    assign wr_en = psel & penable & pwrite & addr_hit(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;

    // Pending selection register, software side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_sel <= `TTR_SEL_RST;
        end else if (wr_en && paddr == `TTR_ADDR_SEL) begin
            pend_sel <= pwdata[`TTR_SEL_W-1:0];
        end
    end

    // Sync bus drive enables, active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_n <= ~`TTR_MASTER_RST;
        end else if (wr_en && paddr == `TTR_ADDR_MASTER) begin
            master_n <= ~pwdata[`TTR_SB_W-1:0];
        end
    end

    // Software trigger strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_acq <= 1'b0;
            sw_out <= 1'b0;
        end else begin
            sw_acq <= wr_en && paddr == `TTR_ADDR_CMD && pwdata[`TTR_CMD_SW_ACQ];
            sw_out <= wr_en && paddr == `TTR_ADDR_CMD && pwdata[`TTR_CMD_SW_OUT];
        end
    end

    // Active selection follows pending only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel <= `TTR_SEL_RST;
        end else begin
            if (!acq_busy) begin
                act_sel.atrig <= pend_sel.atrig;
                act_sel.scan <= pend_sel.scan;
                act_sel.conv <= pend_sel.conv;
                act_sel.acq_fall <= pend_sel.acq_fall;
            end
            if (!out_busy) begin
                act_sel.otrig <= pend_sel.otrig;
                act_sel.upd <= pend_sel.upd;
                act_sel.wave_fall <= pend_sel.wave_fall;
            end
            // Shared tick changes only when both sides rest
            if (!acq_busy && !out_busy) begin
                act_sel.tick <= pend_sel.tick;
            end
        end
    end

    // Master tick source
    always_comb begin
        case (act_sel.tick)
            `TTR_TICK_INT: tick_now = 1'b1;
            `TTR_TICK_EXT: tick_now = rise[`TTR_PIN_TICK];
            `TTR_TICK_SYNC: tick_now = rise[`TTR_PIN_SB + `TTR_SB_TICK];
            default: tick_now = 1'b1;
        endcase
    end

    // Aux 0 claimed by convert excludes scan use
    assign aux_conv = (act_sel.conv == `TTR_SRC_AUX);

    // Acquisition trigger
    always_comb begin
        case (act_sel.atrig)
            `TTR_TRIG_SW: acq_ev = sw_acq;
            `TTR_TRIG_EXT: acq_ev = act_sel.acq_fall ? fall[`TTR_PIN_ACQ] :
                                                     rise[`TTR_PIN_ACQ];
            `TTR_TRIG_ANA: acq_ev = analog_trigger;
            `TTR_TRIG_SYNC: acq_ev = rise[`TTR_PIN_SB + `TTR_SB_ACQ];
            default: acq_ev = sw_acq;
        endcase
        if (aux_conv) begin
            acq_ev = 1'b0;
        end
    end

    // Scan begin
    always_comb begin
        case (act_sel.scan)
            `TTR_SRC_INT: scan_ev = int_scan_pulse;
            `TTR_SRC_AUX: scan_ev = rise[`TTR_PIN_AUX0];
            `TTR_SRC_SYNC: scan_ev = rise[`TTR_PIN_SB + `TTR_SB_SCAN];
            default: scan_ev = int_scan_pulse;
        endcase
        if (aux_conv) begin
            scan_ev = 1'b0;
        end
    end

    // Convert strobe; reserved code falls back to internal
    always_comb begin
        case (act_sel.conv)
            `TTR_SRC_INT: conv_ev = int_conv_pulse;
            `TTR_SRC_AUX: conv_ev = rise[`TTR_PIN_AUX0];
            `TTR_SRC_SYNC: conv_ev = rise[`TTR_PIN_SB + `TTR_SB_CONV];
            default: conv_ev = int_conv_pulse;
        endcase
    end

    // Output trigger
    always_comb begin
        case (act_sel.otrig)
            `TTR_TRIG_SW: otrig_ev = sw_out;
            `TTR_TRIG_EXT: otrig_ev = act_sel.wave_fall ? fall[`TTR_PIN_WAVE] :
                                                        rise[`TTR_PIN_WAVE];
            `TTR_TRIG_ANA: otrig_ev = analog_trigger;
            `TTR_TRIG_SYNC: otrig_ev = rise[`TTR_PIN_SB + `TTR_SB_OTRIG];
            default: otrig_ev = sw_out;
        endcase
    end

    // Update strobe; reserved code falls back to internal
    always_comb begin
        case (act_sel.upd)
            `TTR_SRC_INT: upd_ev = int_upd_pulse;
            `TTR_SRC_AUX: upd_ev = rise[`TTR_PIN_AUX1];
            `TTR_SRC_SYNC: upd_ev = rise[`TTR_PIN_SB + `TTR_SB_UPD];
            default: upd_ev = int_upd_pulse;
        endcase
    end

    assign ev = {upd_ev, otrig_ev, conv_ev, scan_ev, acq_ev};

    // Events wait for the next tick; event on a tick goes out at once
    // Aux 0 convert also drops scan and trigger events already waiting
    assign ev_keep = {3'h7, {2{~aux_conv}}};
    assign next_fire = (pend | ev) & ev_keep & {5{tick_now}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 5'h00;
        end else if (tick_now) begin
            pend <= 5'h00;
        end else begin
            pend <= (pend | ev) & ev_keep;
        end
    end

    // Registered routed outputs, all on the one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_tick <= 1'b0;
            acq_trigger <= 1'b0;
            scan_begin <= 1'b0;
            convert_strobe <= 1'b0;
            output_trigger <= 1'b0;
            output_update_strobe <= 1'b0;
        end else begin
            master_tick <= tick_now;
            acq_trigger <= next_fire[0];
            scan_begin <= next_fire[1];
            convert_strobe <= next_fire[2];
            output_trigger <= next_fire[3];
            output_update_strobe <= next_fire[4];
        end
    end

    // Master cards forward their own timing on the sync bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_bus_out <= '0;
        end else begin
            sync_bus_out[`TTR_SB_TICK] <= tick_now;
            sync_bus_out[`TTR_SB_ACQ] <= next_fire[0];
            sync_bus_out[`TTR_SB_SCAN] <= next_fire[1];
            sync_bus_out[`TTR_SB_CONV] <= next_fire[2];
            sync_bus_out[`TTR_SB_OTRIG] <= next_fire[3];
            sync_bus_out[`TTR_SB_UPD] <= next_fire[4];
        end
    end

    assign sync_bus_oe_n = master_n;

    // Read data captured in the setup phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == `TTR_ADDR_SEL) begin
            next_prdata[`TTR_SEL_W-1:0] = pend_sel;
        end else if (paddr == `TTR_ADDR_MASTER) begin
            next_prdata[`TTR_SB_W-1:0] = ~master_n;
        end else if (paddr == `TTR_ADDR_STATUS) begin
            next_prdata[`TTR_ST_SEL_LSB +: `TTR_SEL_W] = act_sel;
            next_prdata[`TTR_ST_ACQ_BUSY] = acq_busy;
            next_prdata[`TTR_ST_OUT_BUSY] = out_busy;
            next_prdata[`TTR_ST_PENDING] = (pend_sel != act_sel);
            next_prdata[`TTR_ST_MASTER_LSB +: `TTR_SB_W] = ~master_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end
endmodule

`default_nettype wire

// [tb/ttr_router_monitor.sv]
`include "ttr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ttr_router_monitor (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`TTR_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Sources
    input wire logic int_scan_pulse,
    input wire logic int_conv_pulse,
    input wire logic int_upd_pulse,
    input wire logic analog_trigger,
    input wire logic acq_busy,
    input wire logic out_busy,
    input wire logic aux_input_0,
    input wire logic aux_input_1,
    // Routed
    input wire logic master_tick,
    input wire logic acq_trigger,
    input wire logic scan_begin,
    input wire logic convert_strobe,
    input wire logic output_update_strobe
);
    logic [13:0] sel_q;
    logic [1:0] settle;
    logic ok;
    logic t0;
    assign ok = settle == 2'h0;
    assign t0 = ok && sel_q[1:0] != 2'h1 && sel_q[1:0] != 2'h2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 14'h0000;
        end else if (psel && penable && pwrite && paddr == `TTR_ADDR_SEL) begin
            sel_q <= pwdata[13:0];
        end
    end
    // Quiet time after any write or busy spell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 2'h3;
        end else if ((psel && pwrite) || acq_busy || out_busy) begin
            settle <= 2'h3;
        end else if (!ok) begin
            settle <= settle - 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unmapped_err: assert property (psel && penable
        |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0)) else $error("bad pslverr");
    a_tick_internal: assert property (t0 |-> master_tick)
        else $error("tick missing");
    a_conv_internal: assert property (t0 && !sel_q[7] && !sel_q[6] && int_conv_pulse
        |=> convert_strobe) else $error("convert missing");
    a_aux_conv_mute: assert property (ok && sel_q[7:6] == 2'h1
        |-> !scan_begin && !acq_trigger) else $error("scan or trigger leaked");
    a_aux0_edge: assert property (t0 && sel_q[7:6] == 2'h1 && $rose(aux_input_0)
        |-> ##[3:5] convert_strobe) else $error("aux0 convert missing");
    a_conv_single: assert property (t0 && sel_q[7:6] == 2'h1 && convert_strobe
        |=> (!convert_strobe) [*2]) else $error("extra convert");
    a_aux1_edge: assert property (t0 && sel_q[11:10] == 2'h1 && $rose(aux_input_1)
        |-> ##[3:5] output_update_strobe) else $error("aux1 update missing");
    a_upd_internal: assert property (t0 && sel_q[11] == sel_q[10] && int_upd_pulse
        |=> output_update_strobe) else $error("update missing");
    a_scan_internal: assert property (t0 && sel_q[7:6] != 2'h1
        && sel_q[5] == sel_q[4] && int_scan_pulse |=> scan_begin) else $error("scan missing");
    a_analog_acq: assert property (t0 && sel_q[7:6] != 2'h1 && sel_q[3:2] == 2'h2
        && analog_trigger |=> acq_trigger) else $error("analog trigger missing");
endmodule
bind ttr_router ttr_router_monitor u_mon (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pslverr, .int_scan_pulse, .int_conv_pulse, .int_upd_pulse,
    .analog_trigger, .acq_busy, .out_busy, .aux_input_0, .aux_input_1, .master_tick,
    .acq_trigger, .scan_begin, .convert_strobe, .output_update_strobe);
`default_nettype wire

// [tb/ttr_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module ttr_far_end (
    // Clock
    input wire logic pclk,
    // Pins and sync bus toward the card
    output logic [4:0] pin,
    output logic [5:0] sync_bus_in,
    input wire logic [5:0] sync_bus_out,
    input wire logic [5:0] sync_bus_oe_n
);
    logic [5:0] far_q;
    initial begin
        pin = 5'h00;
        far_q = 6'h00;
    end
    // Card owns the lines whose enable is low
    assign sync_bus_in = (sync_bus_oe_n & far_q) | (~sync_bus_oe_n & sync_bus_out);
    // High for w cycles then low for w; w of 3 keeps every width rule
    task automatic pulse(input int i, input int w, input logic sb);
        @(posedge pclk);
        if (sb) far_q[i] <= 1'b1;
        else pin[i] <= 1'b1;
        repeat (w) @(posedge pclk);
        if (sb) far_q[i] <= 1'b0;
        else pin[i] <= 1'b0;
        repeat (w) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`include "ttr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, err_q;
    logic [31:0] pwdata, prdata, rdat;
    logic int_scan_pulse, int_conv_pulse, int_upd_pulse, analog_trigger, acq_busy, out_busy;
    logic [4:0] pin;
    logic [5:0] sb_in, sb_out, oe_n, outs;
    int errors = 0;
    int n_compared = 0;
    int cnt[6] = '{default: 0};
    int c, m;
    always #12.5 pclk = ~pclk;
    ttr_router u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .int_scan_pulse, .int_conv_pulse, .int_upd_pulse, .analog_trigger,
        .acq_busy, .out_busy, .external_tick_input(pin[0]), .acq_ext_trigger_pin(pin[1]),
        .wave_ext_trigger_pin(pin[2]), .aux_input_0(pin[3]), .aux_input_1(pin[4]),
        .sync_bus_in(sb_in), .sync_bus_out(sb_out), .sync_bus_oe_n(oe_n),
        .master_tick(outs[0]), .acq_trigger(outs[1]), .scan_begin(outs[2]),
        .convert_strobe(outs[3]), .output_trigger(outs[4]), .output_update_strobe(outs[5]));
    ttr_far_end u_far (.pclk, .pin, .sync_bus_in(sb_in), .sync_bus_out(sb_out),
        .sync_bus_oe_n(oe_n));
    // Random internal pulses; pulse counts per routed output
    always @(posedge pclk) begin
        {int_scan_pulse, int_conv_pulse, int_upd_pulse, analog_trigger} <= 4'($urandom);
        foreach (cnt[i]) cnt[i] <= cnt[i] + int'(outs[i]);
    end
    task automatic test_done;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            errors++;
            test_done();
        end
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    // Select, send n far-end pulses, count one routed output
    task automatic burst(input int sel, input int i, input logic sb, input int o, input int n);
        int b;
        apb(`TTR_ADDR_SEL, 1'b1, sel);
        repeat (4) @(posedge pclk);
        b = cnt[o];
        repeat (n) u_far.pulse(i, 3, sb);
        repeat (8) @(posedge pclk);
        chk($sformatf("count %0d", o), n, cnt[o] - b);
    endtask
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        {int_scan_pulse, int_conv_pulse, int_upd_pulse, analog_trigger} = 4'h0;
        {acq_busy, out_busy} = 2'h0;
        void'($urandom(41));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`TTR_ADDR_SEL, 0);
        rchk(`TTR_ADDR_STATUS, 0);
        chk("oe_n", 32'h3F, oe_n);
        rchk(12'h010, 0);
        chk("pslverr", 1, err_q);
        repeat (8) begin
            m = $urandom;
            apb(`TTR_ADDR_SEL, 1'b1, m);
            rchk(`TTR_ADDR_SEL, m & 32'h3FFF);
            repeat (30) @(posedge pclk);
        end
        burst(32'h0040, 3, 1'b0, 3, 3);
        burst(32'h0050, 3, 1'b0, 3, 2);
        burst(32'h0010, 3, 1'b0, 2, 2);
        burst(32'h0400, 4, 1'b0, 5, 2);
        burst(32'h0004, 1, 1'b0, 1, 2);
        burst(32'h1004, 1, 1'b0, 1, 2);
        burst(32'h2100, 2, 1'b0, 4, 2);
        burst(32'h000C, 1, 1'b1, 1, 2);
        burst(32'h0020, 2, 1'b1, 2, 2);
        burst(32'h0080, 3, 1'b1, 3, 2);
        burst(32'h0300, 4, 1'b1, 4, 2);
        burst(32'h0800, 5, 1'b1, 5, 2);
        burst(32'h0001, 0, 1'b0, 0, 4);
        burst(32'h0002, 0, 1'b1, 0, 3);
        apb(`TTR_ADDR_SEL, 1'b1, 0);
        c = cnt[1];
        m = cnt[4];
        apb(`TTR_ADDR_CMD, 1'b1, 3);
        repeat (4) @(posedge pclk);
        chk("sw acq", 1, cnt[1] - c);
        chk("sw out", 1, cnt[4] - m);
        rchk(`TTR_ADDR_CMD, 0);
        acq_busy <= 1'b1;
        out_busy <= 1'b1;
        apb(`TTR_ADDR_SEL, 1'b1, 8);
        rchk(`TTR_ADDR_STATUS, 32'h0007_0000);
        acq_busy <= 1'b0;
        out_busy <= 1'b0;
        repeat (3) @(posedge pclk);
        rchk(`TTR_ADDR_STATUS, 8);
        m = $urandom;
        apb(`TTR_ADDR_MASTER, 1'b1, m);
        rchk(`TTR_ADDR_MASTER, m & 32'h3F);
        chk("oe_n", ~m & 32'h3F, oe_n);
        chk("sb tick", 1, sb_out[0]);
        test_done();
    end
endmodule
`default_nettype wire
